/* File: logic/fgp_edge_catch.sv */
`timescale 1ns/1ps

module fgp_edge_catch
   import fgp_pkg::*;
(
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // pins and enables
   input  wire logic [FGP_W-1:0]     pin_in,
   input  wire fgp_pkg::fgp_edge_cfg_t cfg,
   // events
   output logic      [FGP_W-1:0]     edge_evt,
   output logic                      wake_req
);

   logic [2*FGP_W-1:0] tog;
   logic [2*FGP_W-1:0] sync1_ff;
   logic [2*FGP_W-1:0] sync2_ff;
   logic [2*FGP_W-1:0] sync3_ff;

   // ********************************************************************
   // clockless capture, one toggle per pin and edge kind
   // ********************************************************************
   for (genvar i = 0; i < FGP_W; i++)
   begin : g_bit
      logic rtog_ff;
      logic ftog_ff;
      always_ff @(posedge pin_in[i] or negedge presetn)
      begin
         if (!presetn)
            rtog_ff <= 1'b0;
         else if (cfg.rise[i])
            rtog_ff <= ~rtog_ff;
      end
      always_ff @(negedge pin_in[i] or negedge presetn)
      begin
         if (!presetn)
            ftog_ff <= 1'b0;
         else if (cfg.fall[i])
            ftog_ff <= ~ftog_ff;
      end
      assign tog[i]         = rtog_ff;
      assign tog[FGP_W + i] = ftog_ff;
   end

   // ********************************************************************
   // crossing into pclk
   // ********************************************************************
   // two synchroniser stages plus sync3_ff as the history stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
      end
      else
      begin
         sync1_ff <= tog;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         edge_evt <= '0;
      else
         edge_evt <= (sync2_ff[FGP_W-1:0] ^ sync3_ff[FGP_W-1:0])
                   | (sync2_ff[2*FGP_W-1:FGP_W] ^ sync3_ff[2*FGP_W-1:FGP_W]);
   end

   // wake without a clock
   // combinational on purpose: pclk may be stopped in power-down
   assign wake_req = |(tog ^ sync3_ff);

endmodule

/* File: logic/fgp_pkg.sv */
package fgp_pkg;

   // ********************************************************************
   // port geometry
   // ********************************************************************
   localparam int FGP_W  = 32;
   localparam int FGP_AW = 12;

   // ********************************************************************
   // register byte offsets
   // ********************************************************************
   localparam logic [11:0] FGP_DIR_OFS  = 12'h000;
   localparam logic [11:0] FGP_MASK_OFS = 12'h004;
   localparam logic [11:0] FGP_PIN_OFS  = 12'h008;
   localparam logic [11:0] FGP_SET_OFS  = 12'h00C;
   localparam logic [11:0] FGP_CLR_OFS  = 12'h010;
   localparam logic [11:0] FGP_OUT_OFS  = 12'h014;
   localparam logic [11:0] FGP_RISE_OFS = 12'h018;
   localparam logic [11:0] FGP_FALL_OFS = 12'h01C;
   localparam logic [11:0] FGP_STAT_OFS = 12'h020;
   localparam logic [11:0] FGP_IEN_OFS  = 12'h024;

   // ********************************************************************
   // reset values
   // ********************************************************************
   localparam logic [31:0] FGP_DIR_RST  = 32'h0000_0000;
   localparam logic [31:0] FGP_MASK_RST = 32'h0000_0000;
   localparam logic [31:0] FGP_OUT_RST  = 32'h0000_0000;
   localparam logic [31:0] FGP_EDGE_RST = 32'h0000_0000;
   localparam logic [31:0] FGP_STAT_RST = 32'h0000_0000;
   localparam logic [31:0] FGP_IEN_RST  = 32'h0000_0000;

   // ********************************************************************
   // types
   // ********************************************************************
   typedef struct packed {
      logic [FGP_W-1:0] rise;
      logic [FGP_W-1:0] fall;
   } fgp_edge_cfg_t;

endpackage

/* File: logic/fgp_port.sv */
`timescale 1ns/1ps

// Behaviour
// - pins not taken by a peripheral are driven and sampled by this block.
// - each bit has its own direction control, changeable at run time.
// - after reset every pin is an input with its driver off.
// - ones written to set drive bits high, to clear drive them low, zeros leave bits alone.
// - software reads both the output register and the sampled pin levels.
// - the mask register keeps masked bits out of output writes and pin reads.
// - one full-width write updates the whole port at once.
// - byte and halfword accesses update only the addressed lanes.
// - each interrupt-capable pin can flag a rising edge, a falling edge or both.
// - edge capture works with no clock running.
// - any enabled pin edge can raise a wake-up request.
// - the block drives one interrupt line combining its flags.
module fgp_port
   import fgp_pkg::*;
(
   // clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [fgp_pkg::FGP_AW-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // pins
   input  wire logic [fgp_pkg::FGP_W-1:0] gpio_in,
   input  wire logic [fgp_pkg::FGP_W-1:0] periph_sel,
   output logic      [fgp_pkg::FGP_W-1:0] gpio_out,
   output logic      [fgp_pkg::FGP_W-1:0] gpio_oe,
   // events
   output logic                           irq,
   output logic                           wake_req
);
   import fgp_pkg::*;

   logic [31:0]   dir_ff;
   logic [31:0]   mask_ff;
   logic [31:0]   out_ff;
   logic [31:0]   nxt_out;
   logic [31:0]   pin_ff;
   logic [31:0]   stat_ff;
   logic [31:0]   nxt_stat;
   logic [31:0]   ien_ff;
   logic [31:0]   rdmux;
   logic [31:0]   wlane;
   logic [31:0]   wbits;
   logic [31:0]   edge_evt;
   fgp_edge_cfg_t edge_cfg_ff;
   logic          wr_acc;
   logic          rd_setup;
   logic          mapped;

   // ********************************************************************
   // decode helpers
   // ********************************************************************
   function automatic logic [31:0] lane_bits(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++)
         m[8*b +: 8] = {8{strb[b]}};
      return m;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [31:0] lane);
      return (old & ~lane) | (d & lane);
   endfunction

   function automatic logic hit(input logic [FGP_AW-1:0] a,
                                input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // ********************************************************************
   // bus handshake
   // ********************************************************************
   // zero wait states: data is prepared in the setup cycle
   assign pready   = 1'b1;
   assign wr_acc   = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign wlane    = lane_bits(pstrb);
   assign wbits    = wlane & ~mask_ff;

   always_comb
   begin
      mapped = hit(paddr, FGP_DIR_OFS)  | hit(paddr, FGP_MASK_OFS)
             | hit(paddr, FGP_PIN_OFS)  | hit(paddr, FGP_SET_OFS)
             | hit(paddr, FGP_CLR_OFS)  | hit(paddr, FGP_OUT_OFS)
             | hit(paddr, FGP_RISE_OFS) | hit(paddr, FGP_FALL_OFS)
             | hit(paddr, FGP_STAT_OFS) | hit(paddr, FGP_IEN_OFS);
   end

   assign pslverr = psel & penable & ~mapped;

   // ********************************************************************
   // configuration registers
   // ********************************************************************
   // per-bit direction
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dir_ff <= FGP_DIR_RST;
      else if (wr_acc && hit(paddr, FGP_DIR_OFS))
         dir_ff <= merge(dir_ff, pwdata, wlane);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask_ff <= FGP_MASK_RST;
      else if (wr_acc && hit(paddr, FGP_MASK_OFS))
         mask_ff <= merge(mask_ff, pwdata, wlane);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         edge_cfg_ff.rise <= FGP_EDGE_RST;
         edge_cfg_ff.fall <= FGP_EDGE_RST;
      end
      else if (wr_acc && hit(paddr, FGP_RISE_OFS))
         edge_cfg_ff.rise <= merge(edge_cfg_ff.rise, pwdata, wlane);
      else if (wr_acc && hit(paddr, FGP_FALL_OFS))
         edge_cfg_ff.fall <= merge(edge_cfg_ff.fall, pwdata, wlane);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ien_ff <= FGP_IEN_RST;
      else if (wr_acc && hit(paddr, FGP_IEN_OFS))
         ien_ff <= merge(ien_ff, pwdata, wlane);
   end

   // ********************************************************************
   // output register
   // ********************************************************************
   always_comb
   begin
      nxt_out = out_ff;
      if (wr_acc)
      begin
         if (hit(paddr, FGP_SET_OFS))
            nxt_out = out_ff | (pwdata & wbits);
         else if (hit(paddr, FGP_CLR_OFS))
            nxt_out = out_ff & ~(pwdata & wbits);
         else if (hit(paddr, FGP_PIN_OFS) || hit(paddr, FGP_OUT_OFS))
            nxt_out = merge(out_ff, pwdata, wbits);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_ff <= FGP_OUT_RST;
      else
         out_ff <= nxt_out;
   end

   // ********************************************************************
   // pins
   // ********************************************************************
   // peripheral pins released
   assign gpio_out = out_ff;
   assign gpio_oe  = dir_ff & ~periph_sel;

   // pins are synchronous to pclk, one sample stage only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_ff <= '0;
      else
         pin_ff <= gpio_in;
   end

   // ********************************************************************
   // edge events and interrupt
   // ********************************************************************
   fgp_edge_catch u_edge
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .pin_in   (gpio_in),
      .cfg      (edge_cfg_ff),
      .edge_evt (edge_evt),
      .wake_req (wake_req)
   );

   always_comb
   begin
      nxt_stat = stat_ff;
      if (wr_acc && hit(paddr, FGP_STAT_OFS))
         nxt_stat = stat_ff & ~(pwdata & wlane);
      nxt_stat = nxt_stat | edge_evt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stat_ff <= FGP_STAT_RST;
      else
         stat_ff <= nxt_stat;
   end

   assign irq = |(stat_ff & ien_ff);

   // ********************************************************************
   // read path
   // ********************************************************************
   always_comb
   begin
      rdmux = '0;
      if (hit(paddr, FGP_DIR_OFS))
         rdmux = dir_ff;
      else if (hit(paddr, FGP_MASK_OFS))
         rdmux = mask_ff;
      else if (hit(paddr, FGP_PIN_OFS))
         rdmux = pin_ff & ~mask_ff;
      else if (hit(paddr, FGP_OUT_OFS) || hit(paddr, FGP_SET_OFS))
         rdmux = out_ff;
      else if (hit(paddr, FGP_RISE_OFS))
         rdmux = edge_cfg_ff.rise;
      else if (hit(paddr, FGP_FALL_OFS))
         rdmux = edge_cfg_ff.fall;
      else if (hit(paddr, FGP_STAT_OFS))
         rdmux = stat_ff;
      else if (hit(paddr, FGP_IEN_OFS))
         rdmux = ien_ff;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (rd_setup)
         prdata <= rdmux;
   end

   // ********************************************************************
   // checks
   // ********************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   reset_inputs_a : assert property (
      disable iff (1'b0) !presetn |=> (gpio_oe == '0) && (out_ff == '0))
      else $error("pins not inputs after reset");

   dir_write_a : assert property (
      (wr_acc && hit(paddr, FGP_DIR_OFS) && pstrb == 4'hF)
      |=> dir_ff == $past(pwdata))
      else $error("direction write lost");

   set_bits_a : assert property (
      (wr_acc && hit(paddr, FGP_SET_OFS))
      |=> (out_ff & $past(pwdata & wbits)) == $past(pwdata & wbits))
      else $error("set did not drive bits high");

   clr_bits_a : assert property (
      (wr_acc && hit(paddr, FGP_CLR_OFS))
      |=> (out_ff & $past(pwdata & wbits)) == '0)
      else $error("clear did not drive bits low");

   mask_keep_a : assert property (
      wr_acc |=> (out_ff & $past(mask_ff)) == ($past(out_ff) & $past(mask_ff)))
      else $error("masked output bit changed");

   whole_write_a : assert property (
      (wr_acc && hit(paddr, FGP_PIN_OFS) && pstrb == 4'hF && mask_ff == '0)
      |=> out_ff == $past(pwdata))
      else $error("whole port write failed");

   lane_keep_a : assert property (
      (wr_acc && !pstrb[0]) |=> out_ff[7:0] == $past(out_ff[7:0]))
      else $error("unaddressed lane changed");

   pin_read_a : assert property (
      (rd_setup && hit(paddr, FGP_PIN_OFS))
      |=> prdata == $past(pin_ff & ~mask_ff))
      else $error("pin readback wrong");

   flag_set_a : assert property (
      (edge_evt != '0) |=> (stat_ff & $past(edge_evt)) == $past(edge_evt))
      else $error("edge event lost");

   flag_sticky_a : assert property (
      !(wr_acc && hit(paddr, FGP_STAT_OFS))
      |=> (stat_ff & $past(stat_ff)) == $past(stat_ff))
      else $error("flag dropped without clear");

   irq_follow_a : assert property (
      ((edge_evt & ien_ff) != '0) |=> irq)
      else $error("enabled edge raised no interrupt");

   set_write_c  : cover property (wr_acc && hit(paddr, FGP_SET_OFS));
   byte_write_c : cover property (wr_acc && pstrb == 4'h4);
   edge_irq_c   : cover property (!irq ##1 irq);
   clear_c      : cover property (irq ##1 wr_acc && hit(paddr, FGP_STAT_OFS) ##1 !irq);

endmodule

/* File: sim/fgp_pin_model.sv */
`timescale 1ns/1ps

module fgp_pin_model #(
   parameter logic PULL = 1'b1
)
(
   // from the port
   input  wire logic [fgp_pkg::FGP_W-1:0] gpio_out,
   input  wire logic [fgp_pkg::FGP_W-1:0] gpio_oe,
   // outside drivers
   input  wire logic [fgp_pkg::FGP_W-1:0] ext_en,
   input  wire logic [fgp_pkg::FGP_W-1:0] ext_val,
   // seen by the port
   output logic      [fgp_pkg::FGP_W-1:0] gpio_in
);
   import fgp_pkg::*;

   // ********************************************************************
   // pad resolution
   // ********************************************************************
   // port wins pad
   // undriven pads float to the pull level, never keep a stale value
   always_comb
   begin
      gpio_in = (gpio_oe & gpio_out)
              | (~gpio_oe & ((ext_en & ext_val) | ({FGP_W{PULL}} & ~ext_en)));
   end
endmodule

/* File: sim/fgp_tb.sv */
`timescale 1ns/1ps

module tb;
   import fgp_pkg::*;

   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [FGP_AW-1:0] paddr;
   logic [31:0]       pwdata;
   logic [3:0]        pstrb;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [FGP_W-1:0]  gpio_in;
   logic [FGP_W-1:0]  periph_sel;
   logic [FGP_W-1:0]  gpio_out;
   logic [FGP_W-1:0]  gpio_oe;
   logic              irq;
   logic              wake_req;
   logic [FGP_W-1:0]  ext_en;
   logic [FGP_W-1:0]  ext_val;
   logic [31:0]       rdata;
   logic              serr;
   int                err_total;
   int                comparisons;
   logic [11:0]       rst_ofs [7];

   fgp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                 .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
                 .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
                 .periph_sel(periph_sel), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
                 .irq(irq), .wake_req(wake_req));

   fgp_pin_model pads (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_en(ext_en),
                       .ext_val(ext_val), .gpio_in(gpio_in));

   // ********************************************************************
   // checking and closing
   // ********************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ********************************************************************
   // apb master
   // ********************************************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      pstrb  <= s;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
      begin
         err_total++;
         summarize();
      end
      rdata = prdata;
      serr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000, 4'h0);
      chk(nm, rdata, e);
   endtask

   task automatic wait_irq();
      int n;
      for (n = 0; n < 20 && irq !== 1'b1; n++)
         @(posedge pclk);
      if (n == 20)
      begin
         err_total++;
         summarize();
      end
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ********************************************************************
   // main sequence
   // ********************************************************************
   initial
   begin
      err_total   = 0;
      comparisons = 0;
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 12'h000;
      pwdata      = 32'h0000_0000;
      pstrb       = 4'h0;
      periph_sel  = 32'h0000_0F00;
      ext_en      = 32'h0000_00FF;
      ext_val     = 32'h0000_00A5;
      rst_ofs     = '{FGP_DIR_OFS, FGP_MASK_OFS, FGP_OUT_OFS, FGP_RISE_OFS,
                      FGP_FALL_OFS, FGP_STAT_OFS, FGP_IEN_OFS};
      repeat (3) @(posedge pclk);
      chk("oe_rst", gpio_oe, 32'h0000_0000);
      presetn <= 1'b1;
      foreach (rst_ofs[i])
         rd(rst_ofs[i], 32'h0000_0000, "reset");
      // periph-owned pins never get a driver
      wr(FGP_DIR_OFS, 32'hFFFF_FF00);
      #1 chk("oe", gpio_oe, 32'hFFFF_F000);
      rd(FGP_DIR_OFS, 32'hFFFF_FF00, "dir");
      wr(FGP_OUT_OFS, 32'h1234_5678);
      #1 chk("out_full", gpio_out, 32'h1234_5678);
      wr(FGP_SET_OFS, 32'h0000_0081);
      wr(FGP_CLR_OFS, 32'h0000_0070);
      #1 chk("set_clr", gpio_out, 32'h1234_5689);
      rd(FGP_SET_OFS, 32'h1234_5689, "set_rd");
      rd(FGP_CLR_OFS, 32'h0000_0000, "clr_rd");
      apb(1'b1, FGP_OUT_OFS, 32'hAABB_CCDD, 4'b0100);
      rd(FGP_OUT_OFS, 32'h12BB_5689, "lane");
      apb(1'b1, FGP_IEN_OFS, 32'h1234_FFFF, 4'b1100);
      rd(FGP_IEN_OFS, 32'h1234_0000, "half");
      wr(FGP_IEN_OFS, 32'h0000_0000);
      wr(FGP_MASK_OFS, 32'hFFFF_0000);
      wr(FGP_PIN_OFS, 32'h0000_0000);
      #1 chk("pin_wr", gpio_out, 32'h12BB_0000);
      wr(FGP_SET_OFS, 32'hFFFF_FFFF);
      #1 chk("set_mask", gpio_out, 32'h12BB_FFFF);
      repeat (3) @(posedge pclk);
      rd(FGP_PIN_OFS, 32'h0000_FFA5, "pin_rd");
      wr(12'h100, 32'hFFFF_FFFF);
      chk("slverr", {31'h0, serr}, 32'h0000_0001);
      rd(12'h100, 32'h0000_0000, "unmapped");
      // edge flags: quiet pins first, stale events cleared after setup
      ext_val <= 32'h0000_0000;
      wr(FGP_MASK_OFS, 32'h0000_0000);
      wr(FGP_PIN_OFS, 32'h5A5A_0000);
      #1 chk("pin_full", gpio_out, 32'h5A5A_0000);
      wr(FGP_RISE_OFS, 32'h0000_0005);
      wr(FGP_FALL_OFS, 32'h0000_0006);
      repeat (6) @(posedge pclk);
      wr(FGP_STAT_OFS, 32'hFFFF_FFFF);
      @(posedge pclk);
      ext_val <= 32'h0000_0007;
      #1 chk("wake", {31'h0, wake_req}, 32'h0000_0001);
      repeat (8) @(posedge pclk);
      chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
      chk("wake_idle", {31'h0, wake_req}, 32'h0000_0000);
      rd(FGP_STAT_OFS, 32'h0000_0005, "stat_rise");
      wr(FGP_IEN_OFS, 32'h0000_0007);
      #1 chk("irq_on", {31'h0, irq}, 32'h0000_0001);
      wr(FGP_STAT_OFS, 32'h0000_0001);
      rd(FGP_STAT_OFS, 32'h0000_0004, "stat_w1c");
      chk("irq_sticky", {31'h0, irq}, 32'h0000_0001);
      wr(FGP_STAT_OFS, 32'h0000_0004);
      #1 chk("irq_off", {31'h0, irq}, 32'h0000_0000);
      @(posedge pclk);
      ext_val <= 32'h0000_0000;
      repeat (2) @(posedge pclk);
      #1 chk("sync_lag", {31'h0, irq}, 32'h0000_0000);
      wait_irq();
      rd(FGP_STAT_OFS, 32'h0000_0006, "stat_fall");
      // second reset in mid-run
      presetn <= 1'b0;
      @(posedge pclk);
      chk("oe_rerst", gpio_oe, 32'h0000_0000);
      chk("out_rerst", gpio_out, 32'h0000_0000);
      presetn <= 1'b1;
      rd(FGP_DIR_OFS, 32'h0000_0000, "dir_rerst");
      summarize();
   end
endmodule
